//--- rtl/mhbi_defines.vh
/*
  Constants for the multiplexed host-bus interface: field positions,
  widths, state codes and byte-mask encodings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef MHBI_DEFINES_VH
`define MHBI_DEFINES_VH

// =====================================================================
// Widths
`define MHBI_DW              16
`define MHBI_SYNC_W          24

// =====================================================================
// Configuration and status bit positions
`define MHBI_CFG_STYLE_BIT   0
`define MHBI_CFG_BURST_RELEASE_IN_BIT  6
`define MHBI_STAT_IRQ_EN_BIT 9

// =====================================================================
// Byte-mask encodings {mask1, mask0}
`define MHBI_BM_WORD         2'h0
`define MHBI_BM_UPPER        2'h1
`define MHBI_BM_LOWER        2'h2
`define MHBI_BM_NONE         2'h3

// =====================================================================
// Master states
`define MHBI_M_IDLE          3'h0
`define MHBI_M_REQ           3'h1
`define MHBI_M_ADDR          3'h2
`define MHBI_M_DATA          3'h3
`define MHBI_M_END           3'h4

// =====================================================================
// Slave states
`define MHBI_S_IDLE          2'h0
`define MHBI_S_RD            2'h1
`define MHBI_S_WR            2'h2

// =====================================================================
// Zero constants
`define MHBI_ZERO16          16'h0000
`define MHBI_ZERO24          24'h0000_00

`endif

//--- rtl/mhbi_sync.v
/*
  Two-flop synchroniser, one per bit.
  Assumes every input bit is a level from outside the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhbi_defines.vh"

module mhbi_sync #(
  parameter W = `MHBI_SYNC_W
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // =====================================================================
  // Per-bit two-stage chain
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

`default_nettype wire

//--- rtl/mhbi_top.v
/*
  Multiplexed host-bus interface: DMA bus master, register-port slave,
  transceiver controls, byte masks, burst release, attention interrupt
  and duplex-dependent modem pins.
  Assumes an external resolver combines out/oe triples into pin levels.
*/
//
// Contract
// [R1] Master drives low address then data on the shared bus lines.
// [R2] Direction driven only while owning bus, valid whole transaction, else released.
// [R3] Slave: direction high means device drives data, low means it captures.
// [R4] Master direction high for read, low for write.
// [R5] Attention interrupt on any status flag while interrupt enable bit set.
// [R6] Read-enable driven only as master, asserted in read data phase only.
// [R7] Drive-enable driven only as master, read address phase and whole write.
// [R8] Strobe marks data phase; master drives, slave samples, else released.
// [R9] Config bit 6 makes pin a burst-release input ending DMA burst.
// [R10] Style bit zero: byte masks driven only as master.
// [R11] Masks: 00 word, 01 upper, 10 lower, 11 none.
// [R12] Half duplex uses modem pins as RTS/CTS, full duplex as GPIO.
// [R13] Request bus on DMA need while grant inactive; hold through transaction.
// [R14] Mastership starts when grant goes low; grant released after request.
// [R15] Port select valid through data phase: low data, high address port.
// [R16] Slave asserts ready with read data or before write; release after strobe/select.
// [R17] Master outputs released after reset and when idle; no request before init.
`timescale 1ns/1ps
`default_nettype none
`include "mhbi_defines.vh"

module mhbi_top (
  input  wire                   ref_clk,
  input  wire                   rst_n,
  // DMA side
  input  wire                   init_done,
  input  wire                   dma_req,
  input  wire                   dma_read,
  input  wire [`MHBI_DW-1:0]    dma_addr,
  input  wire [`MHBI_DW-1:0]    dma_wdata,
  input  wire [1:0]             dma_byte_sel,
  output reg                    dma_done,
  output reg  [`MHBI_DW-1:0]    dma_rdata,
  // Register port side
  input  wire [`MHBI_DW-1:0]    reg_rdata,
  output reg                    reg_wr,
  output reg                    reg_rd,
  output reg                    reg_port_sel,
  output reg  [`MHBI_DW-1:0]    reg_wdata,
  // Configuration and status
  input  wire [`MHBI_DW-1:0]    bus_config_reg,
  input  wire [`MHBI_DW-1:0]    main_status_reg,
  input  wire                   missed_frame_flag,
  input  wire                   mem_error_flag,
  input  wire                   rx_done_flag,
  input  wire                   tx_done_flag,
  input  wire                   primitive_flag,
  input  wire                   full_duplex,
  input  wire                   tx_pending,
  input  wire                   gpio_a_out,
  input  wire                   gpio_a_oe,
  input  wire                   gpio_b_out,
  input  wire                   gpio_b_oe,
  output reg                    clear_to_send,
  output reg                    gpio_b_in,
  // Bus pins
  input  wire [`MHBI_DW-1:0]    mux_addr_data_bus_in,
  output reg  [`MHBI_DW-1:0]    mux_addr_data_bus_out,
  output reg                    mux_addr_data_bus_oe,
  input  wire                   read_dir_in,
  output reg                    read_dir_out,
  output reg                    read_dir_oe,
  input  wire                   data_strobe_n_in,
  output reg                    data_strobe_n_out,
  output reg                    data_strobe_n_oe,
  output reg                    xcvr_read_enable,
  output reg                    xcvr_read_enable_oe,
  output reg                    xcvr_drive_enable,
  output reg                    xcvr_drive_enable_oe,
  input  wire                   byte_mask_0_in,
  output reg                    byte_mask_0,
  output reg                    byte_mask_0_oe,
  output reg                    byte_mask_1,
  output reg                    byte_mask_1_oe,
  output reg                    bus_req_n_out,
  output reg                    bus_req_n_oe,
  input  wire                   bus_grant_n,
  input  wire                   ready_in,
  output reg                    ready_out,
  output reg                    ready_oe,
  input  wire                   chip_sel_n,
  input  wire                   port_sel,
  output reg                    attention_irq_n,
  output reg                    attention_irq_n_oe,
  output reg                    modem_a_out,
  output reg                    modem_a_oe,
  input  wire                   modem_b_in,
  output reg                    modem_b_out,
  output reg                    modem_b_oe
);

  // =====================================================================
  // Pin synchronisers
  wire [`MHBI_SYNC_W-1:0] sync_bus;

  mhbi_sync #(.W(`MHBI_SYNC_W)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    // Active-low pins enter inverted so the cleared chain reads them idle
    .async_in ({modem_b_in, ~byte_mask_0_in, port_sel, ~chip_sel_n, ready_in,
                ~bus_grant_n, ~data_strobe_n_in, read_dir_in, mux_addr_data_bus_in}),
    .sync_out (sync_bus)
  );

  wire [`MHBI_DW-1:0] s_data   = sync_bus[`MHBI_DW-1:0];
  wire                s_dir    = sync_bus[`MHBI_DW];
  wire                s_strb_n = ~sync_bus[`MHBI_DW+1];
  wire                s_gnt_n  = ~sync_bus[`MHBI_DW+2];
  wire                s_ready  = sync_bus[`MHBI_DW+3];
  wire                s_cs_n   = ~sync_bus[`MHBI_DW+4];
  wire                s_psel   = sync_bus[`MHBI_DW+5];
  wire                s_brel_n = ~sync_bus[`MHBI_DW+6];
  wire                s_modb   = sync_bus[`MHBI_DW+7];

  wire style_sel  = bus_config_reg[`MHBI_CFG_STYLE_BIT];
  wire brel_mode  = bus_config_reg[`MHBI_CFG_BURST_RELEASE_IN_BIT];
  wire burst_stop = brel_mode & ~s_brel_n; // [R9]

  reg [2:0] m_state;
  reg [1:0] s_state;
  reg       cur_read;

  // Slave read data shares the bus output register with the master
  wire slave_load = (s_state == `MHBI_S_IDLE) && (m_state == `MHBI_M_IDLE) &&
                    !s_cs_n && !s_strb_n && s_dir;

  // =====================================================================
  // Bus master
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state               <= `MHBI_M_IDLE;
      cur_read              <= 1'b0;
      dma_done              <= 1'b0;
      dma_rdata             <= `MHBI_ZERO16;
      mux_addr_data_bus_out <= `MHBI_ZERO16;
      read_dir_out          <= 1'b0;
      read_dir_oe           <= 1'b0;
      data_strobe_n_out     <= 1'b1;
      data_strobe_n_oe      <= 1'b0;
      xcvr_read_enable      <= 1'b0;
      xcvr_read_enable_oe   <= 1'b0;
      xcvr_drive_enable     <= 1'b0;
      xcvr_drive_enable_oe  <= 1'b0;
      byte_mask_0           <= 1'b1;
      byte_mask_0_oe        <= 1'b0;
      byte_mask_1           <= 1'b1;
      byte_mask_1_oe        <= 1'b0;
      bus_req_n_out         <= 1'b0;
      bus_req_n_oe          <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      case (m_state)
        `MHBI_M_IDLE: begin
          if (slave_load) begin
            mux_addr_data_bus_out <= reg_rdata; // [R3]
          end
          // No request before init, and never while a grant is still out
          if (init_done && dma_req && s_gnt_n && s_state == `MHBI_S_IDLE) begin // [R17]
            bus_req_n_oe <= 1'b1; // [R13]
            m_state      <= `MHBI_M_REQ;
          end
        end
        `MHBI_M_REQ: begin
          if (!s_gnt_n) begin // [R14]
            cur_read              <= dma_read;
            mux_addr_data_bus_out <= dma_addr; // [R1]
            read_dir_out          <= dma_read; // [R4]
            read_dir_oe           <= 1'b1; // [R2]
            data_strobe_n_out     <= 1'b1;
            data_strobe_n_oe      <= 1'b1; // [R8]
            xcvr_drive_enable     <= 1'b1; // [R7]
            xcvr_drive_enable_oe  <= 1'b1;
            xcvr_read_enable      <= 1'b0;
            xcvr_read_enable_oe   <= 1'b1;
            {byte_mask_1, byte_mask_0} <= dma_byte_sel; // [R11]
            byte_mask_1_oe        <= ~style_sel; // [R10]
            // Pin shared with the burst-release input
            byte_mask_0_oe        <= ~style_sel & ~brel_mode; // [R9]
            m_state               <= `MHBI_M_ADDR;
          end
        end
        `MHBI_M_ADDR: begin
          data_strobe_n_out <= 1'b0; // [R8]
          if (cur_read) begin
            xcvr_drive_enable <= 1'b0; // [R7]
            xcvr_read_enable  <= 1'b1; // [R6]
          end else begin
            mux_addr_data_bus_out <= dma_wdata; // [R1]
          end
          m_state <= `MHBI_M_DATA;
        end
        `MHBI_M_DATA: begin
          if (s_ready) begin
            if (cur_read) begin
              dma_rdata <= s_data; // [R1]
            end
            data_strobe_n_out <= 1'b1;
            xcvr_read_enable  <= 1'b0; // [R6]
            dma_done          <= 1'b1;
            m_state           <= `MHBI_M_END;
          end
        end
        `MHBI_M_END: begin
          if (dma_req && !burst_stop) begin // [R9]
            m_state <= `MHBI_M_REQ;
          end else begin
            // Release everything in the same cycle, request included, so grant can drop
            bus_req_n_oe         <= 1'b0; // [R14]
            read_dir_oe          <= 1'b0; // [R2]
            data_strobe_n_oe     <= 1'b0; // [R8]
            xcvr_read_enable_oe  <= 1'b0; // [R6]
            xcvr_drive_enable    <= 1'b0;
            xcvr_drive_enable_oe <= 1'b0; // [R7]
            byte_mask_0_oe       <= 1'b0; // [R17]
            byte_mask_1_oe       <= 1'b0;
            m_state              <= `MHBI_M_IDLE;
          end
        end
        default: begin
          m_state <= `MHBI_M_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Bus slave and shared data drive
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_state              <= `MHBI_S_IDLE;
      mux_addr_data_bus_oe <= 1'b0;
      ready_out            <= 1'b0;
      ready_oe             <= 1'b0;
      reg_wr               <= 1'b0;
      reg_rd               <= 1'b0;
      reg_port_sel         <= 1'b0;
      reg_wdata            <= `MHBI_ZERO16;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      case (s_state)
        `MHBI_S_IDLE: begin
          ready_oe <= 1'b0;
          if (m_state == `MHBI_M_REQ && !s_gnt_n) begin
            mux_addr_data_bus_oe <= 1'b1; // [R1]
          end else if (m_state == `MHBI_M_ADDR && cur_read) begin
            // Turn the bus round for the memory's read data
            mux_addr_data_bus_oe <= 1'b0; // [R1]
          end else if (m_state == `MHBI_M_END) begin
            mux_addr_data_bus_oe <= 1'b0; // [R17]
          end else if (m_state == `MHBI_M_IDLE && !s_cs_n && !s_strb_n) begin
            reg_port_sel <= s_psel; // [R15]
            ready_out    <= 1'b1; // [R16]
            ready_oe     <= 1'b1;
            if (s_dir) begin
              reg_rd               <= 1'b1;
              mux_addr_data_bus_oe <= 1'b1; // [R3]
              s_state              <= `MHBI_S_RD;
            end else begin
              s_state <= `MHBI_S_WR; // [R3]
            end
          end
        end
        `MHBI_S_RD: begin
          if (s_strb_n || s_cs_n) begin
            mux_addr_data_bus_oe <= 1'b0;
            ready_oe             <= 1'b0; // [R16]
            s_state              <= `MHBI_S_IDLE;
          end
        end
        `MHBI_S_WR: begin
          if (s_strb_n || s_cs_n) begin
            // Strobe rise carries valid data; a dropped select aborts
            if (s_strb_n && !s_cs_n) begin
              reg_wdata <= s_data; // [R8]
              reg_wr    <= 1'b1;
            end
            ready_oe <= 1'b0; // [R16]
            s_state  <= `MHBI_S_IDLE;
          end
        end
        default: begin
          s_state <= `MHBI_S_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Interrupt and modem pins
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      attention_irq_n    <= 1'b0;
      attention_irq_n_oe <= 1'b0;
      modem_a_out        <= 1'b1;
      modem_a_oe         <= 1'b0;
      modem_b_out        <= 1'b1;
      modem_b_oe         <= 1'b0;
      clear_to_send      <= 1'b0;
      gpio_b_in          <= 1'b0;
    end else begin
      // Open drain: only ever pulls low
      attention_irq_n    <= 1'b0;
      attention_irq_n_oe <= main_status_reg[`MHBI_STAT_IRQ_EN_BIT] &
                            (missed_frame_flag | mem_error_flag | rx_done_flag |
                             tx_done_flag | primitive_flag); // [R5]
      gpio_b_in <= s_modb;
      if (full_duplex) begin
        modem_a_out   <= gpio_a_out; // [R12]
        modem_a_oe    <= gpio_a_oe;
        modem_b_out   <= gpio_b_out;
        modem_b_oe    <= gpio_b_oe;
        clear_to_send <= 1'b0;
      end else begin
        modem_a_out   <= ~tx_pending; // [R12]
        modem_a_oe    <= 1'b1;
        modem_b_out   <= 1'b1;
        modem_b_oe    <= 1'b0;
        clear_to_send <= ~s_modb;
      end
    end
  end

endmodule

`default_nettype wire

//--- test/mhbi_props.sv
/* Port-level checker for mhbi_top.
   Assumes binding to mhbi_top, ports matched by name, one clock. */
`timescale 1ns/1ps
`default_nettype none
module mhbi_props (
  input wire logic        ref_clk, rst_n, init_done, bus_grant_n, chip_sel_n,
  input wire logic        data_strobe_n_in, data_strobe_n_out, data_strobe_n_oe,
  input wire logic        bus_req_n_oe, read_dir_out, read_dir_oe, dma_done, reg_wr,
  input wire logic        xcvr_read_enable, xcvr_read_enable_oe,
  input wire logic        xcvr_drive_enable, xcvr_drive_enable_oe,
  input wire logic        byte_mask_0_oe, byte_mask_1_oe, ready_oe,
  input wire logic        attention_irq_n, attention_irq_n_oe,
  input wire logic        missed_frame_flag, mem_error_flag, rx_done_flag,
  input wire logic        tx_done_flag, primitive_flag,
  input wire logic [15:0] bus_config_reg, main_status_reg
);
  // ==================================================================
  // Helpers
  wire irq_src = main_status_reg[9] & (missed_frame_flag | mem_error_flag
                 | rx_done_flag | tx_done_flag | primitive_flag);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==================================================================
  // Assertions
  chk_dir_owned: assert property (read_dir_oe |-> bus_req_n_oe)
    else $error("direction driven without bus ownership");
  chk_dir_read: assert property (xcvr_read_enable |-> read_dir_oe && read_dir_out)
    else $error("read data phase without high direction");
  chk_dir_write: assert property (xcvr_drive_enable && data_strobe_n_oe
      && !data_strobe_n_out |-> !read_dir_out)
    else $error("write data phase without low direction");
  chk_xcvr_master: assert property ((xcvr_read_enable_oe || xcvr_drive_enable_oe)
      |-> bus_req_n_oe && !(xcvr_read_enable && xcvr_drive_enable))
    else $error("transceiver controls wrong");
  chk_strobe_owned: assert property (data_strobe_n_oe |-> bus_req_n_oe)
    else $error("strobe driven without bus ownership");
  chk_done_strobe: assert property (dma_done |-> $past(data_strobe_n_oe))
    else $error("transfer done without strobe");
  chk_mask_style: assert property ((byte_mask_0_oe || byte_mask_1_oe)
      |-> bus_req_n_oe && !bus_config_reg[0])
    else $error("byte masks driven out of turn");
  chk_irq_follow: assert property (irq_src |=> attention_irq_n_oe && !attention_irq_n)
    else $error("interrupt missing");
  chk_irq_quiet: assert property (!irq_src |=> !attention_irq_n_oe)
    else $error("interrupt without cause");
  chk_grant_first: assert property ($rose(xcvr_drive_enable_oe) |-> $past(!bus_grant_n, 2))
    else $error("master phase before grant");
  chk_req_init: assert property (!init_done && !bus_req_n_oe |=> !bus_req_n_oe)
    else $error("request before init");
  chk_ready_resp: assert property ($fell(data_strobe_n_in) && !chip_sel_n
      && !bus_req_n_oe |-> ##[1:6] ready_oe)
    else $error("slave ready missing");
  chk_ready_drop: assert property ($rose(data_strobe_n_in) && ready_oe
      && !bus_req_n_oe |-> ##[1:6] !ready_oe)
    else $error("slave ready not released");

  cover property (dma_done && read_dir_out);
  cover property (reg_wr);
  cover property (attention_irq_n_oe);
endmodule

bind mhbi_top mhbi_props u_mhbi_props (.*);
`default_nettype wire

//--- test/mhbi_mem_model.sv
/* Arbiter and shared memory on the far side of the multiplexed bus.
   Assumes the bench resolves the bus lines from all drivers. */
`timescale 1ns/1ps
`default_nettype none
module mhbi_mem_model (
  input wire logic        ref_clk, rst_n, bus_req_n_oe, mux_addr_data_bus_oe,
  input wire logic        read_dir_out, data_strobe_n_oe, data_strobe_n_out,
  input wire logic        byte_mask_0, byte_mask_1,
  input wire logic [15:0] mux_addr_data_bus_out,
  input wire logic [3:0]  wait_cycles,
  output logic            bus_grant_n, mem_ready, mem_oe, cap_dir,
  output logic [15:0]     mem_data, cap_addr, cap_data,
  output logic [1:0]      cap_mask
);
  logic [3:0] cnt;
  wire        data_ph = data_strobe_n_oe && !data_strobe_n_out;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_grant_n <= 1'b1;
      {mem_ready, mem_oe, cap_dir, cnt} <= 7'h00;
      {mem_data, cap_addr, cap_data, cap_mask} <= 50'h0;
    end else begin
      // Grant only follows the request, so it drops after release
      bus_grant_n <= !bus_req_n_oe;
      if (data_ph) begin
        cnt <= cnt + 4'h1;
        mem_ready <= (cnt >= wait_cycles);
        mem_oe <= read_dir_out;
        mem_data <= ~cap_addr;
        if (!read_dir_out) cap_data <= mux_addr_data_bus_out;
      end else begin
        {mem_ready, mem_oe, cnt} <= 6'h00;
        if (data_strobe_n_oe && mux_addr_data_bus_oe && !mem_ready) begin
          cap_addr <= mux_addr_data_bus_out;
          cap_mask <= {byte_mask_1, byte_mask_0};
          cap_dir <= read_dir_out;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- test/test_mux_host_bus_interface.sv
/* Self-checking bench for mhbi_top with the memory model.
   Assumes mhbi_top, mhbi_mem_model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_mux_host_bus_interface;
  logic ref_clk, rst_n, init_done, dma_req, dma_read, full_duplex, tx_pending;
  logic gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe, chip_sel_n, port_sel;
  logic modem_b_in, host_dir, host_strobe;
  logic [15:0] dma_addr, dma_wdata, reg_rdata, bus_config_reg, main_status_reg, host_data;
  logic [1:0] dma_byte_sel;
  logic [4:0] flg;
  logic [3:0] wait_cycles;
  int num_errors, num_checks;
  wire dma_done, reg_wr, reg_rd, reg_port_sel, clear_to_send, gpio_b_in, bus_grant_n;
  wire mux_addr_data_bus_oe, read_dir_out, read_dir_oe, data_strobe_n_out, data_strobe_n_oe;
  wire xcvr_read_enable, xcvr_read_enable_oe, xcvr_drive_enable, xcvr_drive_enable_oe;
  wire byte_mask_0, byte_mask_0_oe, byte_mask_1, byte_mask_1_oe, bus_req_n_out;
  wire bus_req_n_oe, ready_out, ready_oe, attention_irq_n, attention_irq_n_oe;
  wire modem_a_out, modem_a_oe, modem_b_out, modem_b_oe, mem_ready, mem_oe, cap_dir;
  wire [15:0] dma_rdata, reg_wdata, mux_addr_data_bus_out, mem_data, cap_addr, cap_data;
  wire [1:0] cap_mask;
  // ==================================================================
  // Pin resolution between design, memory model and host
  wire [15:0] mux_addr_data_bus_in = mux_addr_data_bus_oe ? mux_addr_data_bus_out
                                     : mem_oe ? mem_data : host_data;
  wire read_dir_in = read_dir_oe ? read_dir_out : host_dir;
  wire data_strobe_n_in = data_strobe_n_oe ? data_strobe_n_out : host_strobe;
  wire ready_in = ready_oe ? ready_out : mem_ready;
  wire byte_mask_0_in = byte_mask_0_oe ? byte_mask_0 : 1'b1;
  wire missed_frame_flag = flg[0], mem_error_flag = flg[1], rx_done_flag = flg[2];
  wire tx_done_flag = flg[3], primitive_flag = flg[4];

  mhbi_top u_mhbi_top (.*);
  mhbi_mem_model u_mhbi_mem_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==================================================================
  // Tasks
  task automatic end_sim();
    begin
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        num_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task automatic dma_xfer(input logic rd, input logic [15:0] a, d, input logic [1:0] s);
    int n;
    begin
      n = 0;
      {dma_read, dma_addr, dma_wdata, dma_byte_sel, dma_req} <= {rd, a, d, s, 1'b1};
      // Drop the need once taken, so the end state sees no burst
      do begin @(posedge ref_clk); n++; end while (bus_req_n_oe !== 1'b1 && n < 200);
      dma_req <= 1'b0;
      do begin @(posedge ref_clk); n++; end while (dma_done !== 1'b1 && n < 200);
      if (n >= 200) num_errors++;
      repeat (8) @(posedge ref_clk);
    end
  endtask

  task automatic slv_wr(input logic p, input logic [15:0] d);
    int n;
    begin
      n = 0;
      {chip_sel_n, port_sel, host_dir, host_data, host_strobe} <= {1'b0, p, 1'b0, d, 1'b0};
      do begin @(posedge ref_clk); n++; end while (ready_oe !== 1'b1 && n < 20);
      host_strobe <= 1'b1;
      do begin @(posedge ref_clk); n++; end while (reg_wr !== 1'b1 && n < 40);
      if (n >= 40) num_errors++;
      chk(reg_wdata, d);
      chk({15'h0, reg_port_sel}, {15'h0, p});
      chip_sel_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
    end
  endtask

  // ==================================================================
  // Tests
  initial begin
    {rst_n, init_done, dma_req, dma_read, full_duplex, tx_pending} = 6'h00;
    {gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe, port_sel, modem_b_in, host_dir} = 7'h00;
    {chip_sel_n, host_strobe} = 2'b11;
    {dma_addr, dma_wdata, bus_config_reg, main_status_reg} = 64'h0;
    reg_rdata = 16'h1234;
    host_data = 16'h5a5a;
    {dma_byte_sel, flg, wait_cycles} = 11'h000;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk({bus_req_n_oe, read_dir_oe, data_strobe_n_oe, mux_addr_data_bus_oe}, 16'h0);
    dma_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(bus_req_n_oe, 1'b0);
    {dma_req, init_done} <= 2'b01;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      wait_cycles <= 4'(i * 2);
      dma_xfer(1'b0, 16'hc3a0 + 16'(i), 16'h9e17 ^ 16'(i << 8), 2'(i));
      chk(cap_addr, 16'hc3a0 + 16'(i));
      chk(cap_data, 16'h9e17 ^ 16'(i << 8));
      chk({14'h0, cap_mask}, 16'(i));
      chk(cap_dir, 1'b0);
    end
    dma_xfer(1'b1, 16'h0ff1, 16'h0000, 2'h0);
    chk(dma_rdata, ~16'h0ff1);
    chk(cap_dir, 1'b1);
    bus_config_reg <= 16'h0001;
    dma_xfer(1'b0, 16'h4002, 16'h1357, 2'h0);
    chk(cap_data, 16'h1357);
    bus_config_reg <= 16'h0000;
    slv_wr(1'b0, 16'ha55a);
    slv_wr(1'b1, 16'h00ff);
    {chip_sel_n, port_sel, host_dir, host_strobe} <= 4'b0010;
    repeat (5) @(posedge ref_clk);
    chk({ready_oe, mux_addr_data_bus_oe, reg_port_sel}, 3'b110);
    chk(mux_addr_data_bus_out, 16'h1234);
    {chip_sel_n, host_strobe} <= 2'b11;
    repeat (6) @(posedge ref_clk);
    chk({ready_oe, mux_addr_data_bus_oe}, 2'b00);
    for (int i = 0; i < 5; i++) begin
      flg <= 5'(1 << i);
      main_status_reg <= 16'h0200;
      repeat (3) @(posedge ref_clk);
      chk({attention_irq_n_oe, attention_irq_n}, 2'b10);
      main_status_reg <= 16'h0000;
      repeat (3) @(posedge ref_clk);
      chk(attention_irq_n_oe, 1'b0);
    end
    {flg, tx_pending} <= 6'h01;
    repeat (5) @(posedge ref_clk);
    chk({modem_a_oe, modem_a_out, clear_to_send}, 3'b101);
    {full_duplex, gpio_a_out, gpio_a_oe} <= 3'b111;
    repeat (5) @(posedge ref_clk);
    chk({modem_a_oe, modem_a_out, clear_to_send, gpio_b_in}, 4'b1100);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
